// ==== src/srf_spi_port.sv ====
module srf_spi_port #(
   parameter logic [7:0] ID_MAKER = 8'h5A, // Arbitrary value
   parameter logic [7:0] ID_PART = 8'h3C // Arbitrary value
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic mosi_in,
   output logic miso_out,
   output logic miso_oe_out,
   input wire srf_pkg::srf_smp_t smp_in,
   input wire logic smp_vld_in,
   input wire srf_pkg::srf_fword_t fifo_in,
   input wire logic fifo_push_in,
   input wire logic act_evt_in,
   input wire logic inact_evt_in,
   output logic interrupt_pin_one_out,
   output logic interrupt_pin_two_out,
   output logic err_user_out,
   output logic single_event_upset_flag_out,
   output logic [srf_pkg::CFG_BITS-1:0] cfg_out
);
   srf_pkg::srf_rx_t lk_q;
   srf_pkg::srf_rx_t nxt_lk;
   srf_pkg::srf_tx_t tx_q;
   srf_pkg::srf_tx_t nxt_tx;
   srf_pkg::srf_core_t q;
   srf_pkg::srf_core_t nxt_q;
   logic [15:0] mem_ff [srf_pkg::FIFO_DEPTH];
   logic [srf_pkg::CHK_W-1:0] calc;
   logic ev;
   logic pop;
   logic drop;
   logic push_ok;
   logic full;
   logic loop;
   logic stat_rd;
   logic fm_wr;
   logic cfg_wr;
   logic [1:0] fmode;
   logic [5:0] a_fold;
   logic [5:0] a_inc;
   logic [5:0] a_sel;
   logic [7:0] rdat;
   logic [15:0] head;
   logic [15:0] head_nx;
   localparam int FIFO_AW_W = srf_pkg::FIFO_AW;
   typedef logic [FIFO_AW_W-1:0] FIFO_AW_T;

   // =========================================
   // Link side, rising edge: receive shifter
   // Whole link logic is held cleared while chip select is high,
   // so every frame starts at bit zero of a command byte
   always_comb
   begin
      nxt_lk = lk_q;
      nxt_lk.cnt = 3'(lk_q.cnt + 3'h1);
      nxt_lk.sh = {lk_q.sh[5:0], mosi_in};
      if (lk_q.cnt == srf_pkg::BIT_LAST)
      begin
         // Byte event only on the eighth bit; a cut byte is lost
         nxt_lk.rxb = {lk_q.sh, mosi_in};
         nxt_lk.tg = ~lk_q.tg;
      end
   end

   always_ff @(posedge sclk_in or posedge cs_n_in)
   begin
      if (cs_n_in)
      begin
         lk_q <= '0;
      end
      else
      begin
         lk_q <= nxt_lk;
      end
   end

   // =========================================
   // Link side, falling edge: transmit shifter
   // Core byte is loaded at the falling edge that opens a byte. It was
   // settled by the core a few core clocks after the previous byte, which
   // leaves margin up to the 8 MHz link rate but not far beyond.
   always_comb
   begin
      nxt_tx = tx_q;
      if (lk_q.cnt == srf_pkg::BIT_FIRST)
      begin
         nxt_tx.sh = q.tx;
         nxt_tx.oe = q.txv;
      end
      else
      begin
         nxt_tx.sh = {tx_q.sh[6:0], 1'b0};
      end
   end

   always_ff @(negedge sclk_in or posedge cs_n_in)
   begin
      if (cs_n_in)
      begin
         tx_q <= '0;
      end
      else
      begin
         tx_q <= nxt_tx;
      end
   end

   assign miso_out = tx_q.sh[7];
   assign miso_oe_out = tx_q.oe;

   // =========================================
   // Core side: check code and derived terms
   srf_ecc_calc u_ecc (
      .data_in(q.cfg),
      .chk_out(calc)
   );

   assign loop = q.cfg[srf_pkg::A_ACTCTL - srf_pkg::A_CFG0]
      [srf_pkg::LOOP_LSB +: 2] == srf_pkg::LM_LOOP;
   assign fmode = q.cfg[srf_pkg::A_FMODE - srf_pkg::A_CFG0][srf_pkg::FM_LSB +: 2];
   assign full = q.cnt == srf_pkg::FIFO_FULL;
   assign head = mem_ff[q.rp];
   assign head_nx = mem_ff[FIFO_AW_T'(q.rp + 1'b1)];
   assign a_fold = (lk_q.rxb > {2'h0, srf_pkg::ADDR_LAST}) ? srf_pkg::ADDR_LAST
      : lk_q.rxb[5:0];
   assign a_inc = (q.addr == srf_pkg::ADDR_LAST) ? srf_pkg::ADDR_LAST
      : 6'(q.addr + 6'h01);
   assign a_sel = (q.st == srf_pkg::ST_ADRR) ? a_fold : a_inc;
   assign cfg_out = q.cfg;
   assign interrupt_pin_one_out = q.act;
   assign interrupt_pin_two_out = q.inact;
   assign err_user_out = q.err;
   assign single_event_upset_flag_out = q.single_event_upset_flag;

   // =========================================
   // Core side: register read mux
   // Both resolutions come from the same captured sample flops
   always_comb
   begin
      logic [11:0] pv;
      logic [2:0] off;
      logic [7:0] stb;
      pv = 12'h000;
      off = 3'(a_sel - srf_pkg::A_PAIR0);
      stb = 8'h00;
      stb[srf_pkg::STB_ACT] = q.act;
      stb[srf_pkg::STB_INACT] = q.inact;
      stb[srf_pkg::STB_SEU] = q.single_event_upset_flag;
      stb[srf_pkg::STB_ERR] = q.err;
      case (off[2:1])
         2'h0: pv = q.smp.x;
         2'h1: pv = q.smp.y;
         2'h2: pv = q.smp.z;
         default: pv = q.smp.t;
      endcase
      rdat = 8'h00;
      if (a_sel == srf_pkg::A_ID0)
         rdat = ID_MAKER;
      else if (a_sel == srf_pkg::A_ID1)
         rdat = ID_PART;
      else if (a_sel == srf_pkg::A_XH)
         rdat = q.smp.x[11:4];
      else if (a_sel == srf_pkg::A_YH)
         rdat = q.smp.y[11:4];
      else if (a_sel == srf_pkg::A_ZH)
         rdat = q.smp.z[11:4];
      else if (a_sel == srf_pkg::A_STAT)
         rdat = stb;
      else if (a_sel == srf_pkg::A_CNTL)
         rdat = q.cnt[7:0];
      else if (a_sel == srf_pkg::A_CNTH)
         rdat = {6'h00, q.cnt[9:8]};
      else if (a_sel >= srf_pkg::A_PAIR0 && a_sel <= srf_pkg::A_PAIRN)
         rdat = off[0] ? {{4{pv[11]}}, pv[11:8]} : pv[7:0];
      else if (a_sel >= srf_pkg::A_CFG0 && a_sel <= srf_pkg::A_CFGN)
         rdat = q.cfg[4'(a_sel - srf_pkg::A_CFG0)];
   end

   // =========================================
   // Core side: command parser, registers, buffer
   always_comb
   begin
      nxt_q = q;
      nxt_q.cs1 = cs_n_in;
      nxt_q.cs2 = q.cs1;
      nxt_q.tg1 = lk_q.tg;
      nxt_q.tg2 = q.tg1;
      nxt_q.tg3 = q.tg2;
      // Link reset may flip the toggle; events are ignored while deselected
      ev = (q.tg2 ^ q.tg3) && !q.cs2;
      pop = 1'b0;
      stat_rd = 1'b0;
      fm_wr = 1'b0;
      cfg_wr = 1'b0;
      nxt_q.upd = 1'b0;
      if (smp_vld_in)
         nxt_q.smp = smp_in;
      case (q.st)
         srf_pkg::ST_CMD:
            if (ev)
            begin
               case (lk_q.rxb)
                  srf_pkg::CMD_WR: nxt_q.st = srf_pkg::ST_ADRW;
                  srf_pkg::CMD_RD: nxt_q.st = srf_pkg::ST_ADRR;
                  srf_pkg::CMD_FIFO:
                  begin
                     nxt_q.st = srf_pkg::ST_FIFO;
                     nxt_q.tx = (q.cnt != 10'h000) ? head[7:0] : 8'h00;
                     nxt_q.txv = 1'b1;
                     nxt_q.hi = 1'b0;
                  end
                  default: nxt_q.st = srf_pkg::ST_IGN;
               endcase
            end
         srf_pkg::ST_ADRW:
            if (ev)
            begin
               nxt_q.addr = a_fold;
               nxt_q.st = srf_pkg::ST_WR;
            end
         srf_pkg::ST_ADRR, srf_pkg::ST_RD:
            if (ev)
            begin
               nxt_q.addr = a_sel;
               nxt_q.tx = rdat;
               nxt_q.txv = 1'b1;
               nxt_q.st = srf_pkg::ST_RD;
               stat_rd = a_sel == srf_pkg::A_STAT;
            end
         srf_pkg::ST_WR:
            if (ev)
            begin
               nxt_q.single_event_upset_flag = 1'b0;
               nxt_q.addr = a_inc;
               if (q.addr >= srf_pkg::A_CFG0 && q.addr <= srf_pkg::A_CFGN)
               begin
                  nxt_q.cfg[4'(q.addr - srf_pkg::A_CFG0)] = lk_q.rxb;
                  cfg_wr = 1'b1;
                  nxt_q.upd = 1'b1;
                  fm_wr = q.addr == srf_pkg::A_FMODE;
               end
            end
         srf_pkg::ST_FIFO:
            if (ev)
            begin
               // Burst has no length limit: each pair pops one entry
               if (q.hi)
               begin
                  pop = q.cnt != 10'h000;
                  nxt_q.tx = (q.cnt > 10'h001) ? head_nx[7:0] : 8'h00;
                  nxt_q.hi = 1'b0;
               end
               else
               begin
                  nxt_q.tx = (q.cnt != 10'h000) ? head[15:8] : 8'h00;
                  nxt_q.hi = 1'b1;
               end
            end
         srf_pkg::ST_IGN:
            nxt_q.txv = 1'b0;
         default:
            nxt_q.st = srf_pkg::ST_CMD;
      endcase
      if (q.cs2)
      begin
         nxt_q.st = srf_pkg::ST_CMD;
         nxt_q.txv = 1'b0;
         nxt_q.hi = 1'b0;
         // Low half already went out: drop the high half to stay aligned
         pop = (q.st == srf_pkg::ST_FIFO) && q.hi && q.cnt != 10'h000;
      end
      // Check bits follow the block one cycle after a write lands
      if (q.upd)
         nxt_q.chk = calc;
      nxt_q.err = (q.chk != calc) && !q.upd;
      // New events win over clears; loop mode needs no service
      nxt_q.act = act_evt_in | (q.act & ~(loop | stat_rd));
      nxt_q.inact = inact_evt_in | (q.inact & ~(loop | stat_rd));
      nxt_q.frz = (fmode == srf_pkg::FM_TRIG && act_evt_in) | (q.frz & ~fm_wr);
      push_ok = fifo_push_in && fmode != srf_pkg::FM_OFF && !q.frz
         && !(fmode == srf_pkg::FM_OLD && full);
      // Overwrite modes drop the oldest entry when full
      drop = push_ok && full && !pop;
      if (push_ok)
         nxt_q.wp = FIFO_AW_T'(q.wp + 1'b1);
      if (pop | drop)
         nxt_q.rp = FIFO_AW_T'(q.rp + 1'b1);
      nxt_q.cnt = 10'(q.cnt + {9'h000, push_ok} - {9'h000, pop | drop});
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         q <= '0;
         q.st <= srf_pkg::ST_CMD;
         // Synchroniser starts at the idle deselected level
         q.cs1 <= 1'b1;
         q.cs2 <= 1'b1;
         q.single_event_upset_flag <= 1'b1;
      end
      else
      begin
         q <= nxt_q;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (push_ok)
         mem_ff[q.wp] <= fifo_in;
   end

   // =========================================
   // Checks
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   AST_ADDR_STOP: assert property (
      (ev && q.st == srf_pkg::ST_RD && q.addr == srf_pkg::ADDR_LAST)
      |=> q.addr == srf_pkg::ADDR_LAST)
      else $error("address moved past last register");

   AST_ERR_FLAG: assert property (
      (q.chk != calc && !q.upd) |=> q.err)
      else $error("check mismatch not flagged");

   AST_CHK_STORE: assert property (
      (ev && q.st == srf_pkg::ST_WR && q.addr >= srf_pkg::A_CFG0
         && q.addr <= srf_pkg::A_CFGN)
      |=> q.upd ##1 (q.chk == $past(calc) && !q.err))
      else $error("check bits not refreshed after write");

   AST_SEU_CLR: assert property (
      (ev && q.st == srf_pkg::ST_WR) |=> !q.single_event_upset_flag [*2])
      else $error("upset flag not cleared by write");

   AST_LOOP_CLR: assert property (
      (loop && q.act && !act_evt_in) |=> !q.act)
      else $error("loop mode kept interrupt");

   AST_ABORT: assert property (
      q.cs2 |=> (q.st == srf_pkg::ST_CMD && !q.txv))
      else $error("deselect did not reset parser");

   AST_DEPTH: assert property (
      q.cnt <= srf_pkg::FIFO_FULL)
      else $error("buffer count above depth");

   AST_FREEZE: assert property (
      (q.frz && !pop && !drop) |=> q.cnt == $past(q.cnt))
      else $error("frozen buffer took samples");

   AST_IGNORE: assert property (
      (q.st == srf_pkg::ST_IGN) |-> !q.txv)
      else $error("ignored command drives output");

   AST_ODD_DROP: assert property (
      (q.cs2 && q.st == srf_pkg::ST_FIFO && q.hi && q.cnt != 10'h000)
      |=> q.rp == FIFO_AW_T'($past(q.rp) + 1'b1))
      else $error("odd read half not discarded");

   AST_WR_QUIET: assert property (
      (q.st == srf_pkg::ST_ADRW || q.st == srf_pkg::ST_WR) |-> !q.txv)
      else $error("output enabled during write");
endmodule

// ==== inc/srf_pkg.sv ====
package srf_pkg;
   localparam logic [7:0] CMD_WR = 8'h0A;
   localparam logic [7:0] CMD_RD = 8'h0B;
   localparam logic [7:0] CMD_FIFO = 8'h0D;
   localparam logic [5:0] A_ID0 = 6'h00;
   localparam logic [5:0] A_ID1 = 6'h01;
   localparam logic [5:0] A_XH = 6'h08;
   localparam logic [5:0] A_YH = 6'h09;
   localparam logic [5:0] A_ZH = 6'h0A;
   localparam logic [5:0] A_STAT = 6'h0B;
   localparam logic [5:0] A_CNTL = 6'h0C;
   localparam logic [5:0] A_CNTH = 6'h0D;
   localparam logic [5:0] A_PAIR0 = 6'h0E;
   localparam logic [5:0] A_PAIRN = 6'h15;
   localparam logic [5:0] A_CFG0 = 6'h20;
   localparam logic [5:0] A_CFGN = 6'h2E;
   localparam logic [5:0] A_ACTCTL = 6'h27;
   localparam logic [5:0] A_FMODE = 6'h28;
   localparam logic [5:0] ADDR_LAST = 6'h3F;
   localparam int CFG_N = 15;
   localparam int CFG_BITS = 120;
   localparam int HAM_W = 7;
   localparam int CHK_W = 8;
   localparam int FIFO_DEPTH = 512;
   localparam int FIFO_AW = 9;
   localparam logic [9:0] FIFO_FULL = 10'h200;
   localparam int LOOP_LSB = 4;
   localparam logic [1:0] LM_LOOP = 2'h3;
   localparam int FM_LSB = 0;
   localparam logic [1:0] FM_OFF = 2'h0;
   localparam logic [1:0] FM_OLD = 2'h1;
   localparam logic [1:0] FM_TRIG = 2'h3;
   localparam int STB_ACT = 4;
   localparam int STB_INACT = 5;
   localparam int STB_SEU = 6;
   localparam int STB_ERR = 7;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;

   typedef enum logic [6:0] {
      ST_CMD = 7'h01,
      ST_ADRW = 7'h02,
      ST_ADRR = 7'h04,
      ST_WR = 7'h08,
      ST_RD = 7'h10,
      ST_FIFO = 7'h20,
      ST_IGN = 7'h40
   } srf_state_t;

   typedef struct packed {
      logic [11:0] x;
      logic [11:0] y;
      logic [11:0] z;
      logic [11:0] t;
   } srf_smp_t;

   typedef struct packed {
      logic [1:0] tag;
      logic [13:0] val;
   } srf_fword_t;

   typedef struct packed {
      logic [2:0] cnt;
      logic [6:0] sh;
      logic [7:0] rxb;
      logic tg;
   } srf_rx_t;

   typedef struct packed {
      logic [7:0] sh;
      logic oe;
   } srf_tx_t;

   typedef struct packed {
      logic cs1;
      logic cs2;
      logic tg1;
      logic tg2;
      logic tg3;
      srf_state_t st;
      logic [5:0] addr;
      logic [7:0] tx;
      logic txv;
      logic hi;
      logic [FIFO_AW-1:0] rp;
      logic [FIFO_AW-1:0] wp;
      logic [9:0] cnt;
      logic frz;
      srf_smp_t smp;
      logic [CFG_N-1:0][7:0] cfg;
      logic [CHK_W-1:0] chk;
      logic upd;
      logic err;
      logic single_event_upset_flag;
      logic act;
      logic inact;
   } srf_core_t;
endpackage

// ==== src/srf_ecc_calc.sv ====
// =========================================
// Check code over the protected block
module srf_ecc_calc (
   input wire logic [srf_pkg::CFG_BITS-1:0] data_in,
   output logic [srf_pkg::CHK_W-1:0] chk_out
);
   // Column of data bit i is i+1: all columns distinct and nonzero,
   // so with overall parity any one or two flipped bits show up
   function automatic logic [srf_pkg::CFG_BITS-1:0] col_mask(input int k);
      logic [srf_pkg::CFG_BITS-1:0] m;
      m = '0;
      for (int i = 0; i < srf_pkg::CFG_BITS; i++)
      begin
         m[i] = ((i + 1) >> k) % 2 == 1;
      end
      return m;
   endfunction

   for (genvar k = 0; k < srf_pkg::HAM_W; k++)
   begin : g_col
      assign chk_out[k] = ^(data_in & col_mask(k));
   end
   assign chk_out[srf_pkg::CHK_W-1] = ^data_in;
endmodule

// ==== verification/srf_spi_master.sv ====
module srf_spi_master (
   input wire logic lclk_in,
   input wire logic miso_in,
   input wire logic miso_oe_in,
   output logic sclk_out,
   output logic cs_n_out,
   output logic mosi_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] tx [64];
   logic [7:0] rx [64];
   logic [63:0] oe_b;
   logic last;
   initial
   begin
      sclk_out = 1'b0;
      cs_n_out = 1'b0;
      mosi_out = 1'b0;
      last = 1'b0;
      // Early deselect edge clears the slave's link flops
      #1;
      cs_n_out = 1'b1;
   end
   // Released line reads as inverse of last bit, never a stale copy
   task automatic xfer(input int nb, input int cut);
      logic b;
      oe_b = '0;
      @(posedge lclk_in);
      cs_n_out <= 1'b0;
      repeat (9) @(posedge lclk_in);
      for (int i = 0; i < nb * 8 + cut; i++)
      begin
         mosi_out <= tx[i/8][7-i%8];
         repeat (6) @(posedge lclk_in);
         b = miso_oe_in ? miso_in : ~last;
         last = b;
         rx[i/8] = {rx[i/8][6:0], b};
         oe_b[i/8] = oe_b[i/8] | miso_oe_in;
         sclk_out <= 1'b1;
         // Long high time leaves the core room to fetch the next byte
         repeat (5) @(posedge lclk_in);
         sclk_out <= 1'b0;
      end
      repeat (3) @(posedge lclk_in);
      cs_n_out <= 1'b1;
      repeat (8) @(posedge lclk_in);
   endtask
endmodule

// ==== verification/tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] ID_M = 8'hA7; // Arbitrary value
   localparam logic [7:0] ID_P = 8'h4E; // Arbitrary value
   logic ref_clk_in, rst_in, lclk, sclk_in, cs_n_in, mosi_in, miso_out, miso_oe_out;
   srf_pkg::srf_smp_t smp_in;
   srf_pkg::srf_fword_t fifo_in;
   logic smp_vld_in, fifo_push_in, act_evt_in, inact_evt_in;
   logic interrupt_pin_one_out, interrupt_pin_two_out, err_user_out;
   logic single_event_upset_flag_out;
   logic [srf_pkg::CFG_BITS-1:0] cfg_out;
   logic [7:0] cm [15];
   logic [15:0] w [8];
   logic [11:0] v;
   int n_errors, checks, hi;
   srf_spi_port #(.ID_MAKER(ID_M), .ID_PART(ID_P)) u_dut (.ref_clk_in, .rst_in, .sclk_in,
      .cs_n_in, .mosi_in, .miso_out, .miso_oe_out, .smp_in, .smp_vld_in, .fifo_in,
      .fifo_push_in, .act_evt_in, .inact_evt_in, .interrupt_pin_one_out,
      .interrupt_pin_two_out, .err_user_out, .single_event_upset_flag_out, .cfg_out);
   srf_spi_master u_m (.lclk_in(lclk), .miso_in(miso_out), .miso_oe_in(miso_oe_out),
      .sclk_out(sclk_in), .cs_n_out(cs_n_in), .mosi_out(mosi_in));
   initial
   begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   initial
   begin
      lclk = 1'b0;
      #3.7;
      forever #6 lclk = ~lclk;
   end
   task automatic chk(input string nm, input logic [119:0] seen, input logic [119:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic rd(input logic [7:0] c, input logic [7:0] a, input int n);
      u_m.tx[0] = c;
      u_m.tx[1] = a;
      u_m.xfer(n + 2, 0);
   endtask
   // Data preloaded in tx[2..]; mirror follows protected bytes only
   task automatic wr(input logic [7:0] a, input int n);
      for (int i = 0; i < n; i++)
         if (a + i >= 8'h20 && a + i <= 8'h2E)
            cm[a+i-8'h20] = u_m.tx[2+i];
      u_m.tx[0] = srf_pkg::CMD_WR;
      u_m.tx[1] = a;
      u_m.xfer(n + 2, 0);
   endtask
   task automatic wr1(input logic [7:0] a, input logic [7:0] d);
      u_m.tx[2] = d;
      wr(a, 1);
   endtask
   task automatic fr(input int n);
      u_m.tx[0] = srf_pkg::CMD_FIFO;
      u_m.xfer(n + 1, 0);
   endtask
   task automatic push_n(input int f, input int n);
      logic [15:0] d;
      for (int i = f; i < f + n; i++)
      begin
         // Only the first eight entries are kept for comparison
         d = 16'($urandom);
         if (i < 8)
            w[i] = d;
         @(posedge ref_clk_in);
         fifo_in <= d;
         fifo_push_in <= 1'b1;
      end
      @(posedge ref_clk_in);
      fifo_push_in <= 1'b0;
   endtask
   task automatic cnt_chk(input logic [9:0] e);
      rd(srf_pkg::CMD_RD, 8'(srf_pkg::A_CNTL), 2);
      chk("count", {u_m.rx[3][1:0], u_m.rx[2]}, e);
   endtask
   task automatic fchk(input int n);
      for (int i = 0; i < n; i++)
      begin
         chk("flo", u_m.rx[1+2*i], w[i][7:0]);
         chk("fhi", u_m.rx[2+2*i], w[i][15:8]);
      end
   endtask
   task automatic ev(input logic a, input logic b);
      @(posedge ref_clk_in);
      act_evt_in <= a;
      inact_evt_in <= b;
      @(posedge ref_clk_in);
      act_evt_in <= 1'b0;
      inact_evt_in <= 1'b0;
   endtask
   function automatic logic [119:0] cfg_exp();
      logic [119:0] e;
      for (int i = 0; i < 15; i++)
         e[8*i+:8] = cm[i];
      return e;
   endfunction
   initial
   begin
      #400us;
      n_errors++;
      stop_test();
   end
   initial
   begin
      logic [7:0] c;
      void'($urandom(89));
      {n_errors, checks} = '0;
      rst_in = 1'b1;
      {smp_in, fifo_in, smp_vld_in, fifo_push_in, act_evt_in, inact_evt_in} = '0;
      foreach (cm[i])
         cm[i] = 8'h00;
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      chk("upset", single_event_upset_flag_out, 1'b1);
      rd(srf_pkg::CMD_RD, 8'(srf_pkg::A_ID0), 2);
      chk("id0", u_m.rx[2], ID_M);
      chk("id1", u_m.rx[3], ID_P);
      chk("oe", u_m.oe_b[3:0], 4'hC);
      // Data byte cut after 5 bits must write nothing
      u_m.tx[0] = srf_pkg::CMD_WR;
      u_m.tx[1] = 8'h20;
      u_m.tx[2] = 8'hFF;
      u_m.xfer(2, 5);
      chk("cut", cfg_out, cfg_exp());
      chk("upset", single_event_upset_flag_out, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         c = 8'($urandom);
         if (c == 8'h0A || c == 8'h0B || c == 8'h0D)
            c = 8'h0C;
         rd(c, 8'h00, 2);
         chk("badcmd", u_m.oe_b[3:0], 4'h0);
      end
      for (int i = 0; i < 15; i++)
         u_m.tx[2+i] = (i == 7 || i == 8) ? 8'h00 : 8'($urandom);
      wr(8'h20, 15);
      chk("cfg", cfg_out, cfg_exp());
      chk("upset", single_event_upset_flag_out, 1'b0);
      chk("err", err_user_out, 1'b0);
      rd(srf_pkg::CMD_RD, 8'h20, 15);
      for (int i = 0; i < 15; i++)
         chk("cfgrd", u_m.rx[2+i], cm[i]);
      // Buffer mode is off here: pushes must be refused
      push_n(0, 2);
      cnt_chk(10'h000);
      // Folded address must not reach the protected register 0x20
      wr1(8'hE0, 8'h55);
      rd(srf_pkg::CMD_RD, 8'h3F, 2);
      chk("top", {u_m.rx[2], u_m.rx[3]}, 16'h0000);
      chk("topcfg", cfg_out, cfg_exp());
      @(posedge ref_clk_in);
      smp_in <= 48'({$urandom, $urandom});
      smp_vld_in <= 1'b1;
      @(posedge ref_clk_in);
      smp_vld_in <= 1'b0;
      rd(srf_pkg::CMD_RD, 8'(srf_pkg::A_XH), 3);
      for (int k = 0; k < 3; k++)
         chk("msb", u_m.rx[2+k], 8'(smp_in >> (40 - 12 * k)));
      rd(srf_pkg::CMD_RD, 8'(srf_pkg::A_PAIR0), 8);
      for (int k = 0; k < 4; k++)
      begin
         v = 12'(smp_in >> (36 - 12 * k));
         chk("pair", {u_m.rx[3+2*k], u_m.rx[2+2*k]}, {{4{v[11]}}, v});
      end
      wr1(8'(srf_pkg::A_FMODE), 8'h02);
      push_n(0, 4);
      fr(8);
      fchk(4);
      push_n(0, 3);
      fr(3);
      fchk(1);
      chk("oddlo", u_m.rx[3], w[1][7:0]);
      fr(2);
      chk("odd", {u_m.rx[2], u_m.rx[1]}, w[2]);
      cnt_chk(10'h000);
      wr1(8'(srf_pkg::A_FMODE), 8'h03);
      push_n(0, 3);
      ev(1'b1, 1'b0);
      push_n(3, 2);
      cnt_chk(10'h003);
      fr(6);
      fchk(3);
      chk("act", interrupt_pin_one_out, 1'b1);
      rd(srf_pkg::CMD_RD, 8'(srf_pkg::A_STAT), 2);
      chk("stat", u_m.rx[2][srf_pkg::STB_ACT], 1'b1);
      chk("pin", interrupt_pin_one_out, 1'b0);
      wr1(8'(srf_pkg::A_ACTCTL), 8'h30);
      ev(1'b1, 1'b1);
      hi = 0;
      repeat (8)
      begin
         #1;
         hi += interrupt_pin_one_out + 2 * interrupt_pin_two_out;
         @(posedge ref_clk_in);
      end
      chk("loop", hi, 3);
      wr1(8'(srf_pkg::A_ACTCTL), 8'h00);
      wr1(8'(srf_pkg::A_FMODE), 8'h01);
      push_n(0, 1);
      push_n(1, 514);
      cnt_chk(10'h200);
      fr(2);
      fchk(1);
      chk("cfgend", cfg_out, cfg_exp());
      chk("errend", err_user_out, 1'b0);
      stop_test();
   end
endmodule
